/* File: src/adc_pkg.sv */
`default_nettype none
package adc_pkg;

  // ****************************************************************
  // register indices, byte address is four times the index
  // ****************************************************************
  localparam logic [5:0] IDX_CFG  = 6'h02;
  localparam logic [5:0] IDX_FIFO = 6'h03;
  localparam logic [5:0] IDX_CTRL = 6'h04;
  localparam logic [5:0] IDX_STAT = 6'h05;
  localparam logic [5:0] IDX_MASK = 6'h06;

  // ****************************************************************
  // reset values and write masks
  // ****************************************************************
  localparam logic [7:0] CFG_RST    = 8'h00;
  localparam logic [7:0] FIFO_RST   = 8'h00;
  localparam logic [7:0] FIFO_WMASK = 8'h67;

  // ****************************************************************
  // field positions
  // ****************************************************************
  localparam int DIV_LSB   = 5;
  localparam int LONG_BIT  = 4;
  localparam int RES_LSB   = 2;
  localparam int SRC_LSB   = 0;
  localparam int SCAN_BIT  = 6;
  localparam int COMB_BIT  = 5;
  localparam int DEPTH_LSB = 0;
  localparam int START_BIT = 0;
  localparam int CONT_BIT  = 1;
  localparam int CMPEN_BIT = 2;
  localparam int DONE_BIT  = 0;

  // ****************************************************************
  // encodings and timing counts in conversion clock ticks
  // ****************************************************************
  localparam logic [1:0] SRC_BUS     = 2'h0;
  localparam logic [1:0] SRC_HALF    = 2'h1;
  localparam logic [1:0] SRC_ALT     = 2'h2;
  localparam logic [1:0] RES_8       = 2'h0;
  localparam logic [1:0] RES_10      = 2'h1;
  localparam logic [3:0] SHORT_TICKS = 4'h4;
  localparam logic [3:0] LONG_TICKS  = 4'hc;
  localparam logic [3:0] RES8_TICKS  = 4'h8;
  localparam logic [3:0] RES10_TICKS = 4'ha;
  localparam logic [3:0] RES12_TICKS = 4'hc;
  localparam logic [1:0] RESP_OKAY   = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  typedef enum logic [1:0] {IDLE, SAMPLE, CONVERT, CHECK} seq_state_e;

endpackage
`default_nettype wire

/* File: src/conv_clk_if.sv */
`timescale 1ns/100ps
`default_nettype none
interface conv_clk_if;
  logic [1:0] input_clock_source;
  logic [1:0] clock_divide_select;
  logic       conv_tick;
  modport ctrl (output input_clock_source, output clock_divide_select, input conv_tick);
  modport gen (input input_clock_source, input clock_divide_select, output conv_tick);
endinterface
`default_nettype wire

/* File: src/conv_clock_gen.sv */
`timescale 1ns/100ps
`default_nettype none
module conv_clock_gen (
  input  wire logic aclk,
  input  wire logic aresetn,
  input  wire logic ce,
  input  wire logic alternate_clock,
  input  wire logic async_conversion_clock,
  conv_clk_if.gen   cg
);

  typedef struct packed {
    logic       alt_m;
    logic       alt_s;
    logic       alt_p;
    logic       ack_m;
    logic       ack_s;
    logic       ack_p;
    logic       half;
    logic [2:0] cnt;
    logic       tick;
  } gen_s;

  gen_s s_q;
  gen_s s_d;
  logic src_tick;

  function automatic logic [2:0] div_limit(input logic [1:0] sel);
    case (sel)
      2'h0:    return 3'h0;
      2'h1:    return 3'h1;
      2'h2:    return 3'h3;
      default: return 3'h7;
    endcase
  endfunction

  // ****************************************************************
  // source select and divider
  // ****************************************************************
  always_comb begin
    s_d      = s_q;
    src_tick = 1'b0;
    s_d.alt_m = alternate_clock;
    s_d.alt_s = s_q.alt_m;
    s_d.alt_p = s_q.alt_s;
    s_d.ack_m = async_conversion_clock;
    s_d.ack_s = s_q.ack_m;
    s_d.ack_p = s_q.ack_s;
    s_d.half  = ~s_q.half;
    s_d.tick  = 1'b0;
    case (cg.input_clock_source)
      adc_pkg::SRC_BUS:  src_tick = 1'b1;
      adc_pkg::SRC_HALF: src_tick = s_q.half;
      adc_pkg::SRC_ALT:  src_tick = s_q.alt_s & ~s_q.alt_p;
      default:           src_tick = s_q.ack_s & ~s_q.ack_p;
    endcase
    if (src_tick) begin
      if (s_q.cnt >= div_limit(cg.clock_divide_select)) begin
        s_d.cnt  = 3'h0;
        s_d.tick = 1'b1;
      end else begin
        s_d.cnt = s_q.cnt + 3'h1;
      end
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_q <= '0;
    end else if (ce) begin
      s_q <= s_d;
    end
  end

  assign cg.conv_tick = s_q.tick;

  // ****************************************************************
  // checks
  // ****************************************************************
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);

  a_div_count: assert property (
    (ce && $past(ce) && s_q.tick) |-> $past(s_q.cnt) >= div_limit($past(cg.clock_divide_select)))
    else $error("tick before divider count reached its limit");

  a_bus_undivided: assert property (
    (ce && cg.input_clock_source == adc_pkg::SRC_BUS && cg.clock_divide_select == 2'h0) |=> s_q.tick)
    else $error("undivided bus clock missed a tick");

  a_divided_gap: assert property (
    (ce && s_q.tick && cg.clock_divide_select != 2'h0) |=> !s_q.tick)
    else $error("divided clock ticked twice in a row");

endmodule
`default_nettype wire

/* File: src/adc_clock_mode_fifo_scan_control.sv */
// Decided for this implementation: the register addresses and the AXI4-Lite register port.
`timescale 1ns/100ps
`default_nettype none
// ****************************************************************
// Summary of operation
// - divide field 00 passes the input clock, 01 halves it.
// - divide field 10 divides by four, 11 divides by eight.
// - config bit 4 picks short (0) or long (1) sample time.
// - bits 3-2 pick 8, 10 or 12 bit results; 11 reserved.
// - source field picks bus, bus/2, alternate or async clock.
// - scan with FIFO on repeats the first FIFO channel until full.
// - continuous scan starts the next conversion when the set finishes, whether or not complete sets.
// - combine select bit 5 only matters while FIFO depth is nonzero.
// - combine 0 ORs compare triggers; complete after any one.
// - combine 1 ANDs compare triggers; complete after all.
// - FIFO control bits 7 and 4-3 are read-only zero.
// - depth 000 disables FIFO; 001..111 give two to eight levels.
// - with FIFO on, complete sets only after the whole set finishes.
// ****************************************************************
module adc_clock_mode_fifo_scan_control (
  input  wire logic        aclk,
  input  wire logic        aresetn,
  input  wire logic        ce,
  input  wire logic        awvalid,
  output logic             awready,
  input  wire logic [7:0]  awaddr,
  input  wire logic        wvalid,
  output logic             wready,
  input  wire logic [31:0] wdata,
  input  wire logic [3:0]  wstrb,
  output logic             bvalid,
  input  wire logic        bready,
  output logic [1:0]       bresp,
  input  wire logic        arvalid,
  output logic             arready,
  input  wire logic [7:0]  araddr,
  output logic             rvalid,
  input  wire logic        rready,
  output logic [31:0]      rdata,
  output logic [1:0]       rresp,
  input  wire logic        alternate_clock,
  input  wire logic        async_conversion_clock,
  input  wire logic        compare_trigger,
  output logic             conversion_active,
  output logic             conversion_done,
  output logic [2:0]       channel_slot,
  output logic [3:0]       fifo_fill_level,
  output logic             conversion_complete_flag,
  output logic             irq
);

  typedef struct packed {
    logic [7:0]          cfg;
    logic [7:0]          fifo;
    logic                cont;
    logic                cmp_en;
    logic                mask;
    logic                status;
    logic                aw_v;
    logic [7:0]          aw_addr;
    logic                w_v;
    logic [7:0]          w_data;
    logic                w_lane0;
    logic                bvalid;
    logic [1:0]          bresp;
    logic                rvalid;
    logic [31:0]         rdata;
    logic [1:0]          rresp;
    logic                rd_fifo;
    adc_pkg::seq_state_e st;
    logic [3:0]          cnt;
    logic [2:0]          slot;
    logic [3:0]          fill;
    logic                or_acc;
    logic                and_acc;
    logic                done;
  } state_s;

  localparam state_s RST = '{
    cfg:     adc_pkg::CFG_RST,
    fifo:    adc_pkg::FIFO_RST,
    st:      adc_pkg::IDLE,
    and_acc: 1'b1,
    default: '0
  };

  state_s     s_q;
  state_s     s_d;
  logic       aw_hs;
  logic       w_hs;
  logic       ar_hs;
  logic       tick;
  logic       fifo_on;
  logic       scan_on;
  logic       and_mode;
  logic [3:0] target;
  logic [3:0] sample_len;
  logic       cmp_hit;
  logic       start;
  logic       launch;
  logic       set_complete;
  logic       read_clear;
  logic [7:0] rbyte;

  conv_clk_if cg ();

  // ****************************************************************
  // address decode
  // ****************************************************************
  function automatic logic hit(input logic [7:0] a, input logic [5:0] idx);
    return (a[7:2] == idx) && (a[1:0] == 2'h0);
  endfunction

  function automatic logic mapped(input logic [7:0] a);
    return hit(a, adc_pkg::IDX_CFG) | hit(a, adc_pkg::IDX_FIFO) |
           hit(a, adc_pkg::IDX_CTRL) | hit(a, adc_pkg::IDX_STAT) |
           hit(a, adc_pkg::IDX_MASK);
  endfunction

  function automatic logic [3:0] res_ticks(input logic [1:0] m);
    case (m)
      adc_pkg::RES_8:  return adc_pkg::RES8_TICKS;
      adc_pkg::RES_10: return adc_pkg::RES10_TICKS;
      default:         return adc_pkg::RES12_TICKS;
    endcase
  endfunction

  // ****************************************************************
  // conversion clock
  // ****************************************************************
  assign cg.input_clock_source  = s_q.cfg[adc_pkg::SRC_LSB +: 2];
  assign cg.clock_divide_select = s_q.cfg[adc_pkg::DIV_LSB +: 2];
  assign tick                   = cg.conv_tick;

  conv_clock_gen u_clock_gen (
    .aclk                   (aclk),
    .aresetn                (aresetn),
    .ce                     (ce),
    .alternate_clock        (alternate_clock),
    .async_conversion_clock (async_conversion_clock),
    .cg                     (cg.gen)
  );

  // ****************************************************************
  // decoded configuration
  // ****************************************************************
  assign fifo_on    = |s_q.fifo[adc_pkg::DEPTH_LSB +: 3];
  assign scan_on    = fifo_on & s_q.fifo[adc_pkg::SCAN_BIT];
  assign and_mode   = fifo_on & s_q.fifo[adc_pkg::COMB_BIT];
  assign target     = fifo_on ? {1'b0, s_q.fifo[adc_pkg::DEPTH_LSB +: 3]} + 4'h1 : 4'h1;
  assign sample_len = s_q.cfg[adc_pkg::LONG_BIT] ? adc_pkg::LONG_TICKS : adc_pkg::SHORT_TICKS;
  assign cmp_hit    = and_mode ? s_q.and_acc : s_q.or_acc;

  assign aw_hs = awvalid & awready;
  assign w_hs  = wvalid & wready;
  assign ar_hs = arvalid & arready;

  // ****************************************************************
  // next state
  // ****************************************************************
  always_comb begin
    s_d          = s_q;
    start        = 1'b0;
    launch       = 1'b0;
    set_complete = 1'b0;
    read_clear   = 1'b0;
    rbyte        = 8'h00;
    s_d.done     = 1'b0;

    // write channel
    if (aw_hs) begin
      s_d.aw_v    = 1'b1;
      s_d.aw_addr = awaddr;
    end
    if (w_hs) begin
      s_d.w_v     = 1'b1;
      s_d.w_data  = wdata[7:0];
      s_d.w_lane0 = wstrb[0];
    end
    if (s_q.bvalid && bready) begin
      s_d.bvalid = 1'b0;
    end
    if (s_q.aw_v && s_q.w_v) begin
      s_d.aw_v   = 1'b0;
      s_d.w_v    = 1'b0;
      s_d.bvalid = 1'b1;
      s_d.bresp  = mapped(s_q.aw_addr) ? adc_pkg::RESP_OKAY : adc_pkg::RESP_SLVERR;
      if (s_q.w_lane0) begin
        if (hit(s_q.aw_addr, adc_pkg::IDX_CFG)) begin
          s_d.cfg = s_q.w_data;
        end
        if (hit(s_q.aw_addr, adc_pkg::IDX_FIFO)) begin
          s_d.fifo = s_q.w_data & adc_pkg::FIFO_WMASK;
        end
        if (hit(s_q.aw_addr, adc_pkg::IDX_CTRL)) begin
          s_d.cont   = s_q.w_data[adc_pkg::CONT_BIT];
          s_d.cmp_en = s_q.w_data[adc_pkg::CMPEN_BIT];
          start      = s_q.w_data[adc_pkg::START_BIT];
        end
        if (hit(s_q.aw_addr, adc_pkg::IDX_MASK)) begin
          s_d.mask = s_q.w_data[adc_pkg::DONE_BIT];
        end
      end
    end

    // read channel
    if (s_q.rvalid && rready) begin
      s_d.rvalid = 1'b0;
    end
    if (hit(araddr, adc_pkg::IDX_CFG)) begin
      rbyte = s_q.cfg;
    end
    if (hit(araddr, adc_pkg::IDX_FIFO)) begin
      rbyte = s_q.fifo;
    end
    if (hit(araddr, adc_pkg::IDX_CTRL)) begin
      rbyte[adc_pkg::CONT_BIT]  = s_q.cont;
      rbyte[adc_pkg::CMPEN_BIT] = s_q.cmp_en;
    end
    if (hit(araddr, adc_pkg::IDX_STAT)) begin
      rbyte[adc_pkg::DONE_BIT] = s_q.status;
    end
    if (hit(araddr, adc_pkg::IDX_MASK)) begin
      rbyte[adc_pkg::DONE_BIT] = s_q.mask;
    end
    if (ar_hs) begin
      s_d.rvalid  = 1'b1;
      s_d.rdata   = {24'h000000, rbyte};
      s_d.rresp   = mapped(araddr) ? adc_pkg::RESP_OKAY : adc_pkg::RESP_SLVERR;
      s_d.rd_fifo = hit(araddr, adc_pkg::IDX_FIFO);
      read_clear  = hit(araddr, adc_pkg::IDX_STAT);
    end

    // conversion sequencer
    case (s_q.st)
      adc_pkg::IDLE: begin
        launch = start;
      end
      adc_pkg::SAMPLE: begin
        if (tick) begin
          if (s_q.cnt <= 4'h1) begin
            s_d.st  = adc_pkg::CONVERT;
            s_d.cnt = res_ticks(s_q.cfg[adc_pkg::RES_LSB +: 2]);
          end else begin
            s_d.cnt = s_q.cnt - 4'h1;
          end
        end
      end
      adc_pkg::CONVERT: begin
        if (tick) begin
          if (s_q.cnt <= 4'h1) begin
            s_d.st      = adc_pkg::CHECK;
            s_d.done    = 1'b1;
            s_d.fill    = s_q.fill + 4'h1;
            s_d.or_acc  = s_q.or_acc | compare_trigger;
            s_d.and_acc = s_q.and_acc & compare_trigger;
          end else begin
            s_d.cnt = s_q.cnt - 4'h1;
          end
        end
      end
      adc_pkg::CHECK: begin
        if (s_q.fill >= target) begin
          set_complete = !s_q.cmp_en || cmp_hit;
          s_d.st       = adc_pkg::IDLE;
          launch       = s_q.cont;
        end else begin
          s_d.st   = adc_pkg::SAMPLE;
          s_d.cnt  = sample_len;
          s_d.slot = scan_on ? 3'h0 : s_q.fill[2:0];
        end
      end
      default: begin
        s_d.st = adc_pkg::IDLE;
      end
    endcase

    if (launch) begin
      s_d.st      = adc_pkg::SAMPLE;
      s_d.cnt     = sample_len;
      s_d.slot    = 3'h0;
      s_d.fill    = 4'h0;
      s_d.or_acc  = 1'b0;
      s_d.and_acc = 1'b1;
    end

    // set wins over the read clear
    s_d.status = (s_q.status & ~read_clear) | set_complete;
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_q <= RST;
    end else if (ce) begin
      s_q <= s_d;
    end
  end

  // ****************************************************************
  // outputs
  // ****************************************************************
  assign awready                  = ce & ~s_q.aw_v & ~s_q.bvalid;
  assign wready                   = ce & ~s_q.w_v & ~s_q.bvalid;
  assign arready                  = ce & ~s_q.rvalid;
  assign bvalid                   = s_q.bvalid;
  assign bresp                    = s_q.bresp;
  assign rvalid                   = s_q.rvalid;
  assign rdata                    = s_q.rdata;
  assign rresp                    = s_q.rresp;
  assign conversion_active        = s_q.st != adc_pkg::IDLE;
  assign conversion_done          = s_q.done;
  assign channel_slot             = s_q.slot;
  assign fifo_fill_level          = s_q.fill;
  assign conversion_complete_flag = s_q.status;
  assign irq                      = s_q.status & s_q.mask;

  // ****************************************************************
  // checks
  // ****************************************************************
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);

  a_sample_length: assert property (
    (ce && s_q.st != adc_pkg::SAMPLE && s_d.st == adc_pkg::SAMPLE) |=>
      s_q.cnt == ($past(s_q.cfg[adc_pkg::LONG_BIT]) ? adc_pkg::LONG_TICKS : adc_pkg::SHORT_TICKS))
    else $error("sample length does not follow long sample select");

  a_result_width: assert property (
    (ce && s_q.st == adc_pkg::SAMPLE && s_d.st == adc_pkg::CONVERT) |=>
      s_q.cnt == res_ticks($past(s_q.cfg[adc_pkg::RES_LSB +: 2])))
    else $error("conversion length does not follow resolution");

  a_scan_first_slot: assert property (
    (ce && s_q.st == adc_pkg::CHECK && s_d.st == adc_pkg::SAMPLE && scan_on) |=> s_q.slot == 3'h0)
    else $error("scan mode left the first channel");

  a_continuous_restart: assert property (
    (ce && set_complete && s_q.cont) |=> s_q.st == adc_pkg::SAMPLE && s_q.fill == 4'h0 && s_q.status)
    else $error("continuous mode did not restart on completion");

  a_or_combine: assert property (
    (ce && s_q.st == adc_pkg::CHECK && s_q.fill >= target && !and_mode && s_q.or_acc) |=> s_q.status)
    else $error("ORed compare did not set completion");

  a_and_combine: assert property (
    (s_q.st == adc_pkg::CHECK && and_mode && s_q.cmp_en && !s_q.and_acc) |-> !set_complete)
    else $error("ANDed compare set completion too early");

  a_reserved_zero: assert property (
    (s_q.rvalid && s_q.rd_fifo) |-> s_q.rdata[7] == 1'b0 && s_q.rdata[4:3] == 2'h0)
    else $error("reserved FIFO control bits read nonzero");

  a_depth_levels: assert property (
    (ce && s_q.st == adc_pkg::CHECK && s_d.st == adc_pkg::SAMPLE) |->
      (launch ? (s_q.cont && s_q.fill >= target) : (fifo_on && s_q.fill < target)))
    else $error("set continued beyond the configured depth");

  a_whole_set: assert property (
    set_complete |-> s_q.fill >= target && s_q.st == adc_pkg::CHECK)
    else $error("completion set before the whole set finished");

  a_single_no_fifo: assert property (
    (ce && s_q.st == adc_pkg::CHECK && !fifo_on && !s_q.cont) |=> s_q.st == adc_pkg::IDLE)
    else $error("non-FIFO conversion did not end after one result");

  a_read_clear: assert property (
    (ar_hs && hit(araddr, adc_pkg::IDX_STAT) && !set_complete) |=> !s_q.status)
    else $error("status read did not clear the flag");

  c_and_complete: cover property (and_mode && set_complete);
  c_scan_restart: cover property (scan_on && set_complete && s_q.cont ##1 s_q.st == adc_pkg::SAMPLE);
  c_clear_collide: cover property (read_clear && set_complete);

endmodule
`default_nettype wire

/* File: test/adc_clock_mode_fifo_scan_control_tb_top.sv */
`timescale 1ns/100ps
`default_nettype none
module adc_clock_mode_fifo_scan_control_tb_top;
  localparam logic [7:0] A_CFG  = {adc_pkg::IDX_CFG, 2'b00};
  localparam logic [7:0] A_FIFO = {adc_pkg::IDX_FIFO, 2'b00};
  localparam logic [7:0] A_CTRL = {adc_pkg::IDX_CTRL, 2'b00};
  localparam logic [7:0] A_STAT = {adc_pkg::IDX_STAT, 2'b00};
  localparam logic [7:0] A_MASK = {adc_pkg::IDX_MASK, 2'b00};
  localparam logic [1:0] OK     = adc_pkg::RESP_OKAY;
  logic        aclk, aresetn, awvalid, wvalid, bready, arvalid, rready;
  logic        alt_clk, async_clk, cmp_trig;
  logic        ce;
  logic [3:0]  wstrb;
  logic        awready, wready, bvalid, arready, rvalid, active, done, flag, irq;
  logic [7:0]  awaddr, araddr;
  logic [31:0] wdata, rdata, d;
  logic [1:0]  bresp, rresp;
  logic [2:0]  slot;
  logic [3:0]  fill;
  int          n_fail, num_checks, nd, cyc, ex, i;
  logic [7:0]  cfgs[10] = '{8'h00, 8'h20, 8'h40, 8'h60, 8'h10, 8'h04, 8'h08, 8'h01, 8'h02, 8'h03};
  int          tks[10]  = '{12, 12, 12, 12, 20, 14, 16, 12, 12, 12};
  int          dvs[10]  = '{1, 2, 4, 8, 1, 1, 1, 2, 8, 6};
  logic [7:0]  cf[4]    = '{8'h21, 8'h01, 8'h21, 8'h20};
  int          ct[4]    = '{2, 2, 1, 1};
  int          cn[4]    = '{2, 2, 2, 1};
  logic        ce_f[4]  = '{1'b0, 1'b1, 1'b1, 1'b1};

  adc_clock_mode_fifo_scan_control u_dut (
    .aclk(aclk), .aresetn(aresetn), .ce(ce),
    .awvalid(awvalid), .awready(awready), .awaddr(awaddr),
    .wvalid(wvalid), .wready(wready), .wdata(wdata), .wstrb(wstrb),
    .bvalid(bvalid), .bready(bready), .bresp(bresp),
    .arvalid(arvalid), .arready(arready), .araddr(araddr),
    .rvalid(rvalid), .rready(rready), .rdata(rdata), .rresp(rresp),
    .alternate_clock(alt_clk), .async_conversion_clock(async_clk),
    .compare_trigger(cmp_trig), .conversion_active(active), .conversion_done(done),
    .channel_slot(slot), .fifo_fill_level(fill),
    .conversion_complete_flag(flag), .irq(irq)
  );

  initial begin
    aclk = 0;
    forever #10 aclk = ~aclk;
  end
  initial begin
    alt_clk = 0;
    forever #80 alt_clk = ~alt_clk;
  end
  initial begin
    async_clk = 0;
    forever #60 async_clk = ~async_clk;
  end

  // ****************************************************************
  // bus tasks and checks
  // ****************************************************************
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    num_checks++;
    if (got !== exp) begin
      n_fail++;
      $display("mismatch t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task final_report;
    $display("checks=%0d mismatches=%0d", num_checks, n_fail);
    if (n_fail == 0 && num_checks > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask

  task automatic tmo(input int n);
    if (n >= 3000) begin
      n_fail++;
      final_report();
    end
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] v, input logic [1:0] er);
    int   n;
    logic b;
    @(posedge aclk);
    awaddr <= a; wdata <= v; awvalid <= 1; wvalid <= 1; bready <= 1;
    b = 0;
    n = 0;
    while (!b && n < 3000) begin
      @(posedge aclk);
      n++;
      if (awvalid && awready) awvalid <= 0;
      if (wvalid && wready) wvalid <= 0;
      if (bvalid) begin
        b = 1;
        bready <= 0;
        chk(bresp, er);
      end
    end
    tmo(n);
  endtask

  task automatic rd(input logic [7:0] a, output logic [31:0] v, input logic [1:0] er);
    int   n;
    logic b;
    @(posedge aclk);
    araddr <= a; arvalid <= 1; rready <= 1;
    b = 0;
    n = 0;
    while (!b && n < 3000) begin
      @(posedge aclk);
      n++;
      if (arvalid && arready) arvalid <= 0;
      if (rvalid) begin
        b = 1;
        rready <= 0;
        v = rdata;
        chk(rresp, er);
      end
    end
    tmo(n);
  endtask

  // start a conversion set, count completed conversions until the sequencer idles
  task automatic run(input logic [7:0] c, input int trig, input logic scan, output int k, output int t);
    int n;
    cmp_trig <= (trig == 1);
    wr(A_CTRL, {24'h0, c}, OK);
    k = 0;
    t = 0;
    n = 0;
    while (n < 3000 && !(k > 0 && !active)) begin
      @(posedge aclk);
      n++;
      if (done) begin
        k++;
        if (k == 1) t = n;
        if (trig == 2) cmp_trig <= 1;
        if (scan) chk(slot, 32'h0);
      end
    end
    tmo(n);
    @(posedge aclk);
  endtask

  // ****************************************************************
  // main sequence
  // ****************************************************************
  initial begin
    aresetn = 0; awvalid = 0; wvalid = 0; bready = 0; arvalid = 0; rready = 0;
    awaddr = 0; araddr = 0; wdata = 0; cmp_trig = 0; n_fail = 0; num_checks = 0;
    ce = 1; wstrb = 4'hf;
    repeat (10) @(posedge aclk);
    aresetn <= 1;
    rd(A_CFG, d, OK);
    chk(d, adc_pkg::CFG_RST);
    rd(A_FIFO, d, OK);
    chk(d, adc_pkg::FIFO_RST);
    wr(A_FIFO, 32'hff, OK);
    rd(A_FIFO, d, OK);
    chk(d, 32'h67);
    wr(A_CFG, 32'ha5, OK);
    rd(A_CFG, d, OK);
    chk(d, 32'ha5);
    // a write with lane 0 off must leave the register alone
    wstrb <= 4'h0;
    wr(A_CFG, 32'h5a, OK);
    wstrb <= 4'hf;
    rd(A_CFG, d, OK);
    chk(d, 32'ha5);
    wr(8'h40, 32'h1, adc_pkg::RESP_SLVERR);
    rd(8'h40, d, adc_pkg::RESP_SLVERR);
    wr(A_FIFO, 32'h0, OK);
    $display("registers test done");
    for (i = 0; i < 10; i++) begin
      wr(A_CFG, {24'h0, cfgs[i]}, OK);
      run(8'h01, 0, 1'b0, nd, cyc);
      ex = tks[i] * dvs[i];
      num_checks++;
      if (cyc < ex - dvs[i] - 3 || cyc > ex + dvs[i] + 3) begin
        n_fail++;
        $display("mismatch t=%0t got=%h exp=%h", $time, cyc, ex);
      end
    end
    $display("clock and timing test done");
    wr(A_CFG, 32'h0, OK);
    for (i = 1; i < 8; i += 6) begin
      wr(A_FIFO, i, OK);
      rd(A_STAT, d, OK);
      run(8'h01, 0, 1'b0, nd, cyc);
      chk(nd, i + 1);
      chk(flag, 1'b1);
      chk(fill, i + 1);
    end
    wr(A_FIFO, 32'h43, OK);
    run(8'h01, 0, 1'b1, nd, cyc);
    chk(nd, 4);
    $display("fifo depth test done");
    for (i = 0; i < 4; i++) begin
      wr(A_FIFO, {24'h0, cf[i]}, OK);
      rd(A_STAT, d, OK);
      run(8'h05, ct[i], 1'b0, nd, cyc);
      chk(nd, cn[i]);
      chk(flag, ce_f[i]);
    end
    $display("compare combine test done");
    wr(A_MASK, 32'h1, OK);
    @(posedge aclk);
    chk(irq, 1'b1);
    rd(A_STAT, d, OK);
    chk(d, 32'h1);
    @(posedge aclk);
    chk(irq, 1'b0);
    rd(A_STAT, d, OK);
    chk(d, 32'h0);
    $display("interrupt test done");
    wr(A_FIFO, 32'h0, OK);
    wr(A_CTRL, 32'h3, OK);
    nd = 0;
    repeat (150) begin
      @(posedge aclk);
      if (done) nd++;
    end
    chk(32'(nd >= 3), 32'h1);
    // clock enable low must freeze the running sequencer and the bus
    ce <= 1'b0;
    @(posedge aclk);
    d = {26'h0, done, active, fill};
    nd = 0;
    repeat (30) begin
      @(posedge aclk);
      if ({26'h0, done, active, fill} != d || awready || wready || arready) nd++;
    end
    chk(nd, 0);
    ce <= 1'b1;
    wr(A_CTRL, 32'h0, OK);
    i = 0;
    while (active && i < 3000) begin
      @(posedge aclk);
      i++;
    end
    tmo(i);
    $display("continuous test done");
    final_report();
  end
endmodule
`default_nettype wire
